// *** rtl/xod_pkg.sv ***
// constants, types and helper functions of the operand decoder
// Operation
// RULE1 - word register codes: acc,count,data,base,sp,bp,si,di
// RULE2 - byte codes: low halves, then high halves
// RULE3 - segment codes: extra, code, stack, data
// RULE4 - mode picks none, sign-extended byte, word displacement
// RULE5 - mode 11 makes operand-select a register
// RULE6 - eight address forms; frame forms default stack
// RULE7 - mode 00 select 110 is direct address
// RULE8 - displacement bytes precede immediate bytes
// RULE9 - address cost 6,5,9,7/8,11/12 clocks
// RULE10 - odd word operand adds four clocks
// RULE11 - fetch uses code, stack uses stack, always
// RULE12 - override redirects operands; string destination stays extra
// RULE13 - six flag effect classes
// RULE14 - register/memory move: 2, 8+ea, 9+ea
// RULE15 - immediate to register/memory: 10+ea clocks
// RULE16 - immediate to register: 4 clocks
// RULE17 - accumulator moves with direct address: 10 clocks
// RULE18 - segment moves: 2, 8+ea, 9+ea clocks
// RULE19 - push: 10 register, 16+ea memory
// RULE20 - exchange: 4, 17+ea, accumulator form 3
// RULE21 - count consumed bytes for instruction boundary
package xod_pkg;

  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE  = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA  = 2'h3;

  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8  = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG    = 2'h3;
  localparam logic [2:0] RM_DIRECT  = 3'h6;

  localparam logic [2:0] EXT_PUSH    = 3'h6;
  localparam logic [2:0] EXT_POP     = 3'h0;
  localparam logic [2:0] EXT_MOV_IMM = 3'h0;

  localparam logic [7:0] EA_CLK_DIRECT    = 8'h06;
  localparam logic [7:0] EA_CLK_SINGLE    = 8'h05;
  localparam logic [7:0] EA_CLK_SINGLE_DP = 8'h09;
  localparam logic [7:0] EA_CLK_PAIR_FAST = 8'h07;
  localparam logic [7:0] EA_CLK_PAIR_SLOW = 8'h08;
  localparam logic [7:0] EA_CLK_FAST_DP   = 8'h0B;
  localparam logic [7:0] EA_CLK_SLOW_DP   = 8'h0C;
  localparam logic [7:0] ODD_WORD_PENALTY = 8'h04;

  localparam logic [7:0] CLK_MOV_RR      = 8'h02;
  localparam logic [7:0] CLK_MOV_MR      = 8'h08;
  localparam logic [7:0] CLK_MOV_RM      = 8'h09;
  localparam logic [7:0] CLK_MOV_IMM_MEM = 8'h0A;
  localparam logic [7:0] CLK_MOV_IMM_REG = 8'h04;
  localparam logic [7:0] CLK_MOV_ACC     = 8'h0A;
  localparam logic [7:0] CLK_PUSH        = 8'h0A;
  localparam logic [7:0] CLK_PUSH_MEM    = 8'h10;
  localparam logic [7:0] CLK_POP         = 8'h08;
  localparam logic [7:0] CLK_POP_MEM     = 8'h11;
  localparam logic [7:0] CLK_EXCHANGE_OP_RR     = 8'h04;
  localparam logic [7:0] CLK_EXCHANGE_OP_MEM    = 8'h11;
  localparam logic [7:0] CLK_EXCHANGE_OP_ACC    = 8'h03;
  localparam logic [7:0] CLK_PREFIX      = 8'h02;

  typedef enum logic [4:0] {
    CLS_NONE, CLS_MOV_RM, CLS_MOV_IMM_RM, CLS_MOV_IMM_REG, CLS_MOV_MEM_ACC,
    CLS_MOV_ACC_MEM, CLS_MOV_TO_SEG, CLS_MOV_FROM_SEG, CLS_PUSH_RM, CLS_PUSH_REG,
    CLS_PUSH_SEG, CLS_POP_RM, CLS_POP_REG, CLS_POP_SEG, CLS_EXCHANGE_OP_RM, CLS_EXCHANGE_OP_ACC,
    CLS_PREFIX
  } xod_class_t;

  // flag effect classes
  typedef enum logic [2:0] {
    FLG_KEEP, FLG_CLEAR, FLG_SET, FLG_RESULT, FLG_UNDEF, FLG_RESTORE
  } xod_flag_t; // RULE13

  typedef enum logic [4:0] {
    REG_ACC_WORD, REG_COUNT_WORD, REG_DATA_WORD, REG_BASE_WORD,
    REG_STACK_PTR, REG_FRAME_PTR, REG_SRC_INDEX, REG_DST_INDEX,
    REG_ACC_LO, REG_COUNT_LO, REG_DATA_LO, REG_BASE_LO,
    REG_ACC_HI, REG_COUNT_HI, REG_DATA_HI, REG_BASE_HI,
    REG_EXTRA_SEG, REG_CODE_SEG, REG_STACK_SEG, REG_DATA_SEG, REG_NONE
  } xod_reg_t;

  typedef enum logic [2:0] {
    ACC_CODE, ACC_STACK, ACC_FRAME, ACC_INDEX, ACC_STR_SRC, ACC_STR_DST
  } xod_acc_t;

  // segment of an access after any override prefix
  function automatic logic [1:0] seg_resolve(input xod_acc_t kind,
                                             input logic ovr_v,
                                             input logic [1:0] ovr);
    logic [1:0] s;
    s = SEG_DATA;
    case (kind)
      ACC_CODE:    s = SEG_CODE; // RULE11
      ACC_STACK:   s = SEG_STACK; // RULE11
      ACC_STR_DST: s = SEG_EXTRA; // RULE12
      ACC_FRAME:   s = ovr_v ? ovr : SEG_STACK; // RULE12
      default:     s = ovr_v ? ovr : SEG_DATA; // RULE12
    endcase
    return s;
  endfunction : seg_resolve

  function automatic xod_class_t classify(input logic [7:0] b);
    xod_class_t c;
    c = CLS_NONE;
    casez (b)
      8'b1000_10??: c = CLS_MOV_RM; // RULE14
      8'b1100_011?: c = CLS_MOV_IMM_RM; // RULE15
      8'b1011_????: c = CLS_MOV_IMM_REG; // RULE16
      8'b1010_000?: c = CLS_MOV_MEM_ACC; // RULE17
      8'b1010_001?: c = CLS_MOV_ACC_MEM; // RULE17
      8'b1000_1110: c = CLS_MOV_TO_SEG; // RULE18
      8'b1000_1100: c = CLS_MOV_FROM_SEG; // RULE18
      8'b1111_1111: c = CLS_PUSH_RM;
      8'b0101_0???: c = CLS_PUSH_REG;
      8'b0101_1???: c = CLS_POP_REG;
      8'b000?_?110: c = CLS_PUSH_SEG;
      8'b000?_?111: c = CLS_POP_SEG;
      8'b1000_1111: c = CLS_POP_RM;
      8'b1000_011?: c = CLS_EXCHANGE_OP_RM;
      8'b1001_0???: c = CLS_EXCHANGE_OP_ACC;
      8'b001?_?110: c = CLS_PREFIX;
      default:      c = CLS_NONE;
    endcase
    return c;
  endfunction : classify

endpackage : xod_pkg

// *** rtl/xod_ea_if.sv ***
// addressing-byte decode bundle between sequencer and address decoder
`timescale 1ns/1ps
interface xod_ea_if;
  import xod_pkg::*;
  logic [7:0] modrm;
  logic       is_mem;
  logic       direct;
  logic       frame_based;
  logic [1:0] disp_len;
  logic [7:0] ea_clk;
  modport dec  (output modrm, input is_mem, direct, frame_based, disp_len, ea_clk);
  modport calc (input modrm, output is_mem, direct, frame_based, disp_len, ea_clk);
endinterface : xod_ea_if

// *** rtl/xod_ea_calc.sv ***
// addressing-byte decode: displacement form, address form and cost
`timescale 1ns/1ps
module xod_ea_calc
  import xod_pkg::*;
(
  xod_ea_if.calc ea
);
  logic [1:0] md;
  logic [2:0] rm;
  logic       pair;
  logic       slow;

  always_comb begin
    md             = ea.modrm[7:6];
    rm             = ea.modrm[2:0];
    pair           = ~rm[2];
    // frame+source and base+dest cost one more clock than the other pairs
    slow           = (rm == 3'h1) || (rm == 3'h2);
    ea.is_mem      = (md != MOD_REG); // RULE5
    ea.direct      = (md == MOD_NODISP) && (rm == RM_DIRECT); // RULE7
    ea.frame_based = ~ea.direct && ((rm == 3'h2) || (rm == 3'h3) || (rm == 3'h6)); // RULE6
    ea.disp_len    = 2'h0;
    ea.ea_clk      = 8'h00;
    case (md)
      MOD_DISP8:  ea.disp_len = 2'h1; // RULE4
      MOD_DISP16: ea.disp_len = 2'h2; // RULE4
      MOD_NODISP: ea.disp_len = ea.direct ? 2'h2 : 2'h0; // RULE7
      default:    ea.disp_len = 2'h0;
    endcase
    if (ea.direct) begin
      ea.ea_clk = EA_CLK_DIRECT; // RULE9
    end else if (ea.is_mem && pair && (md == MOD_NODISP)) begin
      ea.ea_clk = slow ? EA_CLK_PAIR_SLOW : EA_CLK_PAIR_FAST; // RULE9
    end else if (ea.is_mem && pair) begin
      ea.ea_clk = slow ? EA_CLK_SLOW_DP : EA_CLK_FAST_DP; // RULE9
    end else if (ea.is_mem && (md == MOD_NODISP)) begin
      ea.ea_clk = EA_CLK_SINGLE; // RULE9
    end else if (ea.is_mem) begin
      ea.ea_clk = EA_CLK_SINGLE_DP; // RULE9
    end
  end

endmodule : xod_ea_calc

// *** rtl/xod_reg_map.sv ***
// register field to register identity
`timescale 1ns/1ps
module xod_reg_map
  import xod_pkg::*;
(
  input  wire logic [2:0] code,
  input  wire logic       width,
  input  wire logic       seg,
  output xod_reg_t        reg_id
);
  always_comb begin
    if (seg) begin
      reg_id = xod_reg_t'(5'(REG_EXTRA_SEG) + {3'h0, code[1:0]}); // RULE3
    end else if (width) begin
      reg_id = xod_reg_t'({2'h0, code}); // RULE1
    end else begin
      reg_id = xod_reg_t'(5'(REG_ACC_LO) + {2'h0, code}); // RULE2
    end
  end
endmodule : xod_reg_map

// *** rtl/xod_operand_decode.sv ***
// data-transfer operand decoder: byte sequencer and decode result
`timescale 1ns/1ps
module xod_operand_decode
  import xod_pkg::*;
#(
  parameter int CLK_W = 8
)
(
  input  wire logic             CORE_CLK,
  input  wire logic             SYS_RST,
  input  wire logic             BYTE_VALID,
  input  wire logic [7:0]       BYTE_DATA,
  input  wire logic             WORD_ODD_ADDR,
  output logic                  BYTE_READY,
  output logic                  DEC_VALID,
  output xod_class_t            DEC_CLASS,
  output logic                  DEC_WIDTH,
  output logic                  DEC_DIR,
  output xod_reg_t              DEC_REG,
  output xod_reg_t              DEC_RM_REG,
  output logic                  DEC_MEM,
  output logic                  DEC_DIRECT,
  output logic [1:0]            DEC_SEG,
  output logic [1:0]            DEC_STACK_SEG,
  output logic [1:0]            DEC_FETCH_SEG,
  output logic [15:0]           DEC_DISP,
  output logic [15:0]           DEC_IMM,
  output logic [2:0]            DEC_LEN,
  output logic [CLK_W-1:0]      DEC_CLOCKS,
  output xod_flag_t             DEC_FLAGS,
  output logic                  DEC_ILLEGAL
);

  // worst case 17 + 12 + 4 clocks needs six bits
  if (CLK_W < 6 || CLK_W > 8) begin : g_bad_width
    $error("CLK_W must lie between 6 and 8");
  end

  typedef enum logic [2:0] {
    S_OPC, S_MODRM, S_DISP_LO, S_DISP_HI, S_IMM_LO, S_IMM_HI, S_DONE
  } xod_state_t;

  typedef struct packed {
    xod_state_t       st;
    logic             ready;
    logic [7:0]       opc;
    logic [7:0]       modrm;
    logic [1:0]       dlen;
    logic [1:0]       ilen;
    logic [15:0]      disp;
    logic [15:0]      imm;
    logic [2:0]       len;
    logic             ovr_v;
    logic [1:0]       ovr;
    xod_class_t       cls;
    logic             bad;
    logic             o_valid;
    xod_class_t       o_cls;
    logic             o_width;
    logic             o_dir;
    xod_reg_t         o_reg;
    xod_reg_t         o_rm;
    logic             o_mem;
    logic             o_direct;
    logic [1:0]       o_seg;
    logic [1:0]       o_stk;
    logic [1:0]       o_fetch;
    logic [15:0]      o_disp;
    logic [15:0]      o_imm;
    logic [2:0]       o_len;
    logic [CLK_W-1:0] o_clk;
    xod_flag_t        o_flg;
    logic             o_bad;
  } xod_top_t;

  xod_top_t   q_ff;
  xod_top_t   nxt_q;
  xod_ea_if   ea ();
  logic       take;
  logic       has_modrm;
  logic       width;
  logic       mem;
  logic [2:0] reg_code;
  logic       reg_seg;
  logic [7:0] base_clk;
  logic [7:0] tot_clk;
  xod_reg_t   reg_id;
  xod_reg_t   rm_id;
  xod_class_t cls_in;

  // the address decoder sees the byte live while it is being taken
  assign ea.modrm = (q_ff.st == S_MODRM) ? BYTE_DATA : q_ff.modrm;

  xod_ea_calc u_ea (
    .ea (ea.calc)
  );

  xod_reg_map u_reg (
    .code   (reg_code),
    .width  (width),
    .seg    (reg_seg),
    .reg_id (reg_id)
  );

  xod_reg_map u_rm (
    .code   (q_ff.modrm[2:0]),
    .width  (width),
    .seg    (1'b0),
    .reg_id (rm_id)
  );

  always_comb begin
    take      = BYTE_VALID && q_ff.ready;
    cls_in    = classify(BYTE_DATA);
    has_modrm = (q_ff.cls == CLS_MOV_RM) || (q_ff.cls == CLS_MOV_IMM_RM) ||
                (q_ff.cls == CLS_MOV_TO_SEG) || (q_ff.cls == CLS_MOV_FROM_SEG) ||
                (q_ff.cls == CLS_PUSH_RM) || (q_ff.cls == CLS_POP_RM) ||
                (q_ff.cls == CLS_EXCHANGE_OP_RM);
    mem       = (has_modrm && ea.is_mem) ||
                (q_ff.cls == CLS_MOV_MEM_ACC) || (q_ff.cls == CLS_MOV_ACC_MEM);
    width     = 1'b1;
    reg_code  = q_ff.modrm[5:3];
    reg_seg   = 1'b0;
    case (q_ff.cls)
      CLS_MOV_RM, CLS_MOV_IMM_RM, CLS_EXCHANGE_OP_RM: width = q_ff.opc[0];
      CLS_MOV_MEM_ACC, CLS_MOV_ACC_MEM:        width = q_ff.opc[0];
      CLS_MOV_IMM_REG:                         width = q_ff.opc[3];
      default:                                 width = 1'b1;
    endcase
    case (q_ff.cls)
      CLS_MOV_IMM_REG, CLS_PUSH_REG, CLS_POP_REG, CLS_EXCHANGE_OP_ACC: begin
        reg_code = q_ff.opc[2:0]; // RULE16
      end
      CLS_MOV_MEM_ACC, CLS_MOV_ACC_MEM: begin
        reg_code = 3'h0;
      end
      CLS_PUSH_SEG, CLS_POP_SEG, CLS_PREFIX: begin
        reg_code = {1'b0, q_ff.opc[4:3]};
        reg_seg  = 1'b1;
      end
      CLS_MOV_TO_SEG, CLS_MOV_FROM_SEG: begin
        reg_code = {1'b0, q_ff.modrm[4:3]}; // RULE18
        reg_seg  = 1'b1;
      end
      default: begin
        reg_code = q_ff.modrm[5:3];
      end
    endcase
    base_clk = 8'h00;
    case (q_ff.cls)
      CLS_MOV_RM:       base_clk = mem ? (q_ff.opc[1] ? CLK_MOV_MR : CLK_MOV_RM) + ea.ea_clk
                                       : CLK_MOV_RR; // RULE14
      CLS_MOV_IMM_RM:   base_clk = CLK_MOV_IMM_MEM + (mem ? ea.ea_clk : 8'h00); // RULE15
      CLS_MOV_IMM_REG:  base_clk = CLK_MOV_IMM_REG; // RULE16
      CLS_MOV_MEM_ACC,
      CLS_MOV_ACC_MEM:  base_clk = CLK_MOV_ACC; // RULE17
      CLS_MOV_TO_SEG:   base_clk = mem ? CLK_MOV_MR + ea.ea_clk : CLK_MOV_RR; // RULE18
      CLS_MOV_FROM_SEG: base_clk = mem ? CLK_MOV_RM + ea.ea_clk : CLK_MOV_RR; // RULE18
      CLS_PUSH_RM:      base_clk = mem ? CLK_PUSH_MEM + ea.ea_clk : CLK_PUSH; // RULE19
      CLS_PUSH_REG,
      CLS_PUSH_SEG:     base_clk = CLK_PUSH; // RULE19
      CLS_POP_RM:       base_clk = mem ? CLK_POP_MEM + ea.ea_clk : CLK_POP;
      CLS_POP_REG,
      CLS_POP_SEG:      base_clk = CLK_POP;
      CLS_EXCHANGE_OP_RM:      base_clk = mem ? CLK_EXCHANGE_OP_MEM + ea.ea_clk : CLK_EXCHANGE_OP_RR; // RULE20
      CLS_EXCHANGE_OP_ACC:     base_clk = CLK_EXCHANGE_OP_ACC; // RULE20
      CLS_PREFIX:       base_clk = CLK_PREFIX;
      default:          base_clk = 8'h00;
    endcase
    // odd word accesses need a second bus cycle
    tot_clk = base_clk + ((mem && width && WORD_ODD_ADDR) ? ODD_WORD_PENALTY : 8'h00); // RULE10

    nxt_q         = q_ff;
    nxt_q.o_valid = 1'b0;
    case (q_ff.st)
      S_OPC: begin
        if (take) begin
          nxt_q.opc   = BYTE_DATA;
          nxt_q.cls   = cls_in;
          nxt_q.len   = 3'h1; // RULE21
          nxt_q.modrm = 8'h00;
          nxt_q.disp  = 16'h0000;
          nxt_q.imm   = 16'h0000;
          nxt_q.bad   = (cls_in == CLS_NONE);
          nxt_q.dlen  = 2'h0;
          nxt_q.ilen  = 2'h0;
          nxt_q.st    = S_DONE;
          case (cls_in)
            CLS_MOV_RM, CLS_MOV_IMM_RM, CLS_MOV_TO_SEG, CLS_MOV_FROM_SEG,
            CLS_PUSH_RM, CLS_POP_RM, CLS_EXCHANGE_OP_RM: nxt_q.st = S_MODRM;
            CLS_MOV_IMM_REG: begin
              nxt_q.ilen = BYTE_DATA[3] ? 2'h2 : 2'h1; // RULE16
              nxt_q.st   = S_IMM_LO;
            end
            CLS_MOV_MEM_ACC, CLS_MOV_ACC_MEM: begin
              nxt_q.dlen = 2'h2; // RULE17
              nxt_q.st   = S_DISP_LO;
            end
            default: nxt_q.st = S_DONE;
          endcase
        end
      end
      S_MODRM: begin
        if (take) begin
          nxt_q.modrm = BYTE_DATA;
          nxt_q.len   = q_ff.len + 3'h1; // RULE21
          nxt_q.dlen  = ea.disp_len;
          if (q_ff.cls == CLS_MOV_IMM_RM) begin
            nxt_q.ilen = q_ff.opc[0] ? 2'h2 : 2'h1; // RULE15
            nxt_q.bad  = (BYTE_DATA[5:3] != EXT_MOV_IMM);
          end
          if (q_ff.cls == CLS_PUSH_RM) begin
            nxt_q.bad = (BYTE_DATA[5:3] != EXT_PUSH);
          end
          if (q_ff.cls == CLS_POP_RM) begin
            nxt_q.bad = (BYTE_DATA[5:3] != EXT_POP);
          end
          if ((q_ff.cls == CLS_MOV_TO_SEG) || (q_ff.cls == CLS_MOV_FROM_SEG)) begin
            nxt_q.bad = BYTE_DATA[5]; // RULE18
          end
          // displacement always ahead of immediate data
          if (ea.disp_len != 2'h0) begin
            nxt_q.st = S_DISP_LO; // RULE8
          end else if (q_ff.cls == CLS_MOV_IMM_RM) begin
            nxt_q.st = S_IMM_LO;
          end else begin
            nxt_q.st = S_DONE;
          end
        end
      end
      S_DISP_LO: begin
        if (take) begin
          nxt_q.disp = {{8{BYTE_DATA[7]}}, BYTE_DATA}; // RULE4
          nxt_q.len  = q_ff.len + 3'h1; // RULE21
          if (q_ff.dlen == 2'h2) begin
            nxt_q.st = S_DISP_HI;
          end else if (q_ff.ilen != 2'h0) begin
            nxt_q.st = S_IMM_LO; // RULE8
          end else begin
            nxt_q.st = S_DONE;
          end
        end
      end
      S_DISP_HI: begin
        if (take) begin
          nxt_q.disp = {BYTE_DATA, q_ff.disp[7:0]}; // RULE4
          nxt_q.len  = q_ff.len + 3'h1; // RULE21
          nxt_q.st   = (q_ff.ilen != 2'h0) ? S_IMM_LO : S_DONE; // RULE8
        end
      end
      S_IMM_LO: begin
        if (take) begin
          nxt_q.imm = {8'h00, BYTE_DATA};
          nxt_q.len = q_ff.len + 3'h1; // RULE21
          nxt_q.st  = (q_ff.ilen == 2'h2) ? S_IMM_HI : S_DONE;
        end
      end
      S_IMM_HI: begin
        if (take) begin
          nxt_q.imm = {BYTE_DATA, q_ff.imm[7:0]};
          nxt_q.len = q_ff.len + 3'h1; // RULE21
          nxt_q.st  = S_DONE;
        end
      end
      S_DONE: begin
        nxt_q.o_valid  = 1'b1;
        nxt_q.o_cls    = q_ff.cls;
        nxt_q.o_width  = width;
        nxt_q.o_dir    = q_ff.opc[1];
        nxt_q.o_reg    = reg_id;
        nxt_q.o_rm     = (has_modrm && !ea.is_mem) ? rm_id : REG_NONE; // RULE5
        nxt_q.o_mem    = mem;
        nxt_q.o_direct = (has_modrm && ea.direct) || (mem && !has_modrm); // RULE7
        nxt_q.o_seg    = seg_resolve((has_modrm && ea.frame_based) ? ACC_FRAME : ACC_INDEX,
                                     q_ff.ovr_v, q_ff.ovr); // RULE6
        nxt_q.o_stk    = seg_resolve(ACC_STACK, q_ff.ovr_v, q_ff.ovr); // RULE11
        nxt_q.o_fetch  = seg_resolve(ACC_CODE, q_ff.ovr_v, q_ff.ovr); // RULE11
        nxt_q.o_disp   = q_ff.disp;
        nxt_q.o_imm    = q_ff.imm;
        nxt_q.o_len    = q_ff.len; // RULE21
        nxt_q.o_clk    = CLK_W'(tot_clk);
        // data transfers in this group leave every flag alone
        nxt_q.o_flg    = FLG_KEEP; // RULE13
        nxt_q.o_bad    = q_ff.bad;
        // a prefix arms the override for the next instruction only
        nxt_q.ovr_v    = (q_ff.cls == CLS_PREFIX); // RULE12
        nxt_q.ovr      = (q_ff.cls == CLS_PREFIX) ? q_ff.opc[4:3] : q_ff.ovr;
        nxt_q.st       = S_OPC;
      end
      default: nxt_q.st = S_OPC;
    endcase
    nxt_q.ready = (nxt_q.st != S_DONE);
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q_ff       <= '0;
      q_ff.ready <= 1'b1;
      q_ff.o_rm  <= REG_NONE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign BYTE_READY    = q_ff.ready;
  assign DEC_VALID     = q_ff.o_valid;
  assign DEC_CLASS     = q_ff.o_cls;
  assign DEC_WIDTH     = q_ff.o_width;
  assign DEC_DIR       = q_ff.o_dir;
  assign DEC_REG       = q_ff.o_reg;
  assign DEC_RM_REG    = q_ff.o_rm;
  assign DEC_MEM       = q_ff.o_mem;
  assign DEC_DIRECT    = q_ff.o_direct;
  assign DEC_SEG       = q_ff.o_seg;
  assign DEC_STACK_SEG = q_ff.o_stk;
  assign DEC_FETCH_SEG = q_ff.o_fetch;
  assign DEC_DISP      = q_ff.o_disp;
  assign DEC_IMM       = q_ff.o_imm;
  assign DEC_LEN       = q_ff.o_len;
  assign DEC_CLOCKS    = q_ff.o_clk;
  assign DEC_FLAGS     = q_ff.o_flg;
  assign DEC_ILLEGAL   = q_ff.o_bad;

endmodule : xod_operand_decode

// *** tb/xod_operand_decode_checker.sv ***
// assertions on the operand decoder's top-level ports
`timescale 1ns/1ps
module xod_operand_decode_checker
  import xod_pkg::*;
#(
  parameter int CLK_W = 8
)
(
  input wire logic             CORE_CLK,
  input wire logic             SYS_RST,
  input wire logic             WORD_ODD_ADDR,
  input wire logic             BYTE_READY,
  input wire logic             DEC_VALID,
  input wire xod_class_t       DEC_CLASS,
  input wire logic             DEC_WIDTH,
  input wire logic             DEC_MEM,
  input wire xod_reg_t         DEC_RM_REG,
  input wire logic [1:0]       DEC_STACK_SEG,
  input wire logic [1:0]       DEC_FETCH_SEG,
  input wire logic [2:0]       DEC_LEN,
  input wire logic [CLK_W-1:0] DEC_CLOCKS,
  input wire xod_flag_t        DEC_FLAGS
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  a_gap_one_cycle: assert property (!BYTE_READY |=> BYTE_READY && DEC_VALID)
    else $error("ready gap longer than one cycle or no result");
  a_result_pulse: assert property (DEC_VALID |-> !$past(BYTE_READY) ##1 !DEC_VALID)
    else $error("result pulse not one cycle after gap");
  a_fixed_segs: assert property (DEC_VALID |-> DEC_STACK_SEG == SEG_STACK
    && DEC_FETCH_SEG == SEG_CODE) else $error("stack or fetch segment moved");
  a_flags_kept: assert property (DEC_VALID |-> DEC_FLAGS == FLG_KEEP)
    else $error("flag class wrong for transfer");
  a_acc_move_cost: assert property (DEC_VALID && DEC_CLASS inside {CLS_MOV_MEM_ACC,
    CLS_MOV_ACC_MEM} |-> DEC_LEN == 3 && DEC_CLOCKS == ((DEC_WIDTH && $past(WORD_ODD_ADDR)) ? 14 : 10))
    else $error("accumulator move cost wrong");
  a_imm_reg_cost: assert property (DEC_VALID && DEC_CLASS == CLS_MOV_IMM_REG |->
    DEC_CLOCKS == 4 && !DEC_MEM && DEC_LEN == (DEC_WIDTH ? 3 : 2))
    else $error("immediate to register cost wrong");
  a_exchange_op_acc_cost: assert property (DEC_VALID && DEC_CLASS == CLS_EXCHANGE_OP_ACC |->
    DEC_CLOCKS == 3 && DEC_LEN == 1) else $error("accumulator exchange cost wrong");
  a_push_short: assert property (DEC_VALID && DEC_CLASS inside {CLS_PUSH_REG,
    CLS_PUSH_SEG} |-> DEC_CLOCKS == 10) else $error("short push cost wrong");
  a_mem_no_rm_reg: assert property (DEC_VALID && DEC_MEM |-> DEC_RM_REG == REG_NONE)
    else $error("memory operand names a register");
  a_reg_move: assert property (DEC_VALID && !DEC_MEM && DEC_CLASS == CLS_MOV_RM |->
    DEC_CLOCKS == 2 && DEC_RM_REG != REG_NONE) else $error("register move wrong");
endmodule : xod_operand_decode_checker

bind xod_operand_decode xod_operand_decode_checker #(.CLK_W(CLK_W)) u_chk (.CORE_CLK,
  .SYS_RST, .WORD_ODD_ADDR, .BYTE_READY, .DEC_VALID, .DEC_CLASS, .DEC_WIDTH, .DEC_MEM,
  .DEC_RM_REG, .DEC_STACK_SEG, .DEC_FETCH_SEG, .DEC_LEN, .DEC_CLOCKS, .DEC_FLAGS);

// *** tb/xod_fetch_model.sv ***
// instruction fetch stand-in: offers queued bytes in order
`timescale 1ns/1ps
module xod_fetch_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ready,
  output logic      valid,
  output logic [7:0] data
);
  logic [7:0] q [$];
  logic       slow;
  logic       took;
  initial begin
    valid = 1'b0;
    data  = 8'h00;
    slow  = 1'b0;
    took  = 1'b0;
  end
  always @(posedge clk) begin
    took <= valid && ready && !rst;
  end
  // byte held until taken; slow mode idles after each take
  always @(negedge clk) begin
    if (took) begin
      void'(q.pop_front());
    end
    if (q.size() > 0 && !(slow && took)) begin
      valid = 1'b1;
      data  = q[0];
    end else begin
      valid = 1'b0;
      data  = ~data; // released lines must not look stable
    end
  end
endmodule : xod_fetch_model

// *** tb/xod_operand_decode_tb_top.sv ***
// self-checking bench for the operand decoder
`timescale 1ns/1ps
module xod_operand_decode_tb_top;
  import xod_pkg::*;
  logic        CORE_CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        WORD_ODD_ADDR = 1'b0;
  logic        BYTE_VALID, BYTE_READY, DEC_VALID, DEC_WIDTH, DEC_DIR, DEC_MEM;
  logic        DEC_DIRECT, DEC_ILLEGAL;
  logic [7:0]  BYTE_DATA, DEC_CLOCKS;
  logic [1:0]  DEC_SEG, DEC_STACK_SEG, DEC_FETCH_SEG;
  logic [15:0] DEC_DISP, DEC_IMM;
  logic [2:0]  DEC_LEN;
  xod_class_t  DEC_CLASS;
  xod_reg_t    DEC_REG, DEC_RM_REG;
  xod_flag_t   DEC_FLAGS;
  int          errors = 0;
  int          comparisons = 0;

  always #20 CORE_CLK = ~CORE_CLK;

  xod_fetch_model u_fetch (.clk(CORE_CLK), .rst(SYS_RST), .ready(BYTE_READY), .valid(BYTE_VALID),
    .data(BYTE_DATA));
  xod_operand_decode #(.CLK_W(8)) dut (.CORE_CLK, .SYS_RST, .BYTE_VALID, .BYTE_DATA, .WORD_ODD_ADDR,
    .BYTE_READY, .DEC_VALID, .DEC_CLASS, .DEC_WIDTH, .DEC_DIR, .DEC_REG, .DEC_RM_REG, .DEC_MEM,
    .DEC_DIRECT, .DEC_SEG, .DEC_STACK_SEG, .DEC_FETCH_SEG, .DEC_DISP, .DEC_IMM, .DEC_LEN,
    .DEC_CLOCKS, .DEC_FLAGS, .DEC_ILLEGAL);

  task automatic complete_run();
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // the low n bytes of v go out first-to-last, byte n-1 first
  task automatic feed(input int n, input logic [39:0] v, input logic odd);
    WORD_ODD_ADDR = odd;
    for (int i = n - 1; i >= 0; i--) u_fetch.q.push_back(v[8*i +: 8]);
  endtask : feed

  task automatic await_dec();
    for (int i = 0; i < 60; i++) begin
      @(negedge CORE_CLK);
      if (DEC_VALID === 1'b1) return;
    end
    errors++;
    $display("[ERR] %0t no decode result", $time);
    complete_run();
  endtask : await_dec

  task automatic run(input int n, input logic [39:0] v, input logic odd);
    feed(n, v, odd);
    await_dec();
  endtask : run

  task automatic sc_walk();
    for (int o = 0; o < 2; o++) begin
      run(5, 40'hC7_4705_3412, o[0]);
      chk(16'(DEC_CLASS), 16'(CLS_MOV_IMM_RM));
      chk(16'(DEC_CLOCKS), 16'h0013 + 16'(4 * o));
      chk(16'(DEC_LEN), 16'h0005);
      chk(DEC_DISP, 16'h0005);
      chk(DEC_IMM, 16'h1234);
    end
  endtask : sc_walk

  task automatic sc_regs();
    for (int r = 0; r < 8; r++) begin
      run(3, {16'h0000, 8'hB8 | 8'(r), 16'h3412}, 1'b0);
      chk(16'(DEC_REG), 16'(REG_ACC_WORD) + 16'(r));
      chk(DEC_IMM, 16'h1234);
      run(2, {24'h00_0000, 8'hB0 | 8'(r), 8'h56}, 1'b0);
      chk(16'(DEC_REG), 16'(REG_ACC_LO) + 16'(r));
      chk(DEC_IMM, 16'h0056);
    end
  endtask : sc_regs

  task automatic sc_segs();
    for (int s = 0; s < 4; s++) begin
      run(2, {24'h00_0000, 8'h8C, 8'hC0 | 8'(s << 3)}, 1'b0);
      chk(16'(DEC_REG), 16'(REG_EXTRA_SEG) + 16'(s));
      chk({DEC_DIR, DEC_CLOCKS}, 16'h0002);
    end
    run(2, 40'h00_0000_8CE0, 1'b0);
    chk(16'(DEC_ILLEGAL), 16'h0001);
  endtask : sc_segs

  task automatic sc_forms();
    logic [7:0] ea [8] = '{8'h0B, 8'h0C, 8'h0C, 8'h0B, 8'h09, 8'h09, 8'h09, 8'h09};
    u_fetch.slow = 1'b1;
    for (int rm = 0; rm < 8; rm++) begin
      run(3, {16'h0000, 8'h8B, 8'h40 | 8'(rm), 8'hFE}, 1'b0);
      chk(16'(DEC_CLOCKS), 16'h0008 + 16'(ea[rm]));
      chk(DEC_DISP, 16'hFFFE);
      chk(16'(DEC_SEG), 16'((rm inside {2, 3, 6}) ? SEG_STACK : SEG_DATA));
    end
    u_fetch.slow = 1'b0;
    run(2, 40'h00_0000_8BC1, 1'b0);
    chk(16'(DEC_RM_REG), 16'(REG_COUNT_WORD));
    run(4, 40'h00_8B06_3412, 1'b0);
    chk({DEC_DIR, DEC_DIRECT, DEC_CLOCKS}, 16'h030E);
    chk(16'(DEC_SEG), 16'(SEG_DATA));
    run(4, 40'h00_8B86_3412, 1'b0);
    chk({DEC_DIRECT, DEC_CLOCKS}, 16'h0011);
    chk(DEC_DISP, 16'h1234);
  endtask : sc_forms

  // override reaches only the next instruction
  task automatic sc_override();
    feed(4, 40'h00_268B_4602, 1'b0);
    await_dec();
    chk({8'(DEC_CLASS), DEC_CLOCKS}, {8'(CLS_PREFIX), 8'h02});
    await_dec();
    chk(16'(DEC_SEG), 16'(SEG_EXTRA));
    run(3, 40'h00_008B_4602, 1'b0);
    chk(16'(DEC_SEG), 16'(SEG_STACK));
  endtask : sc_override

  task automatic sc_table();
    logic [39:0] code [16] = '{40'h00_00A1_3412, 40'h00_00A2_3412, 40'h00_0000_8AC1,
      40'h00_0000_8907, 40'h00_8E1E_3412, 40'h00_FF36_3412, 40'h00_0000_0050, 40'h00_0000_001E,
      40'h00_0000_87C1, 40'h00_0000_8607, 40'h00_0000_0091, 40'h00_0000_00F4, 40'hC6_0634_12AB,
      40'h00_8F06_3412, 40'h00_0000_0058, 40'h00_0000_001F};
    logic [2:0]  len [16] = '{3'h3, 3'h3, 3'h2, 3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2, 3'h1,
      3'h1, 3'h5, 3'h4, 3'h1, 3'h1};
    logic [7:0]  clk [16] = '{8'h0E, 8'h0A, 8'h02, 8'h0E, 8'h0E, 8'h16, 8'h0A, 8'h0A, 8'h04,
      8'h16, 8'h03, 8'h00, 8'h10, 8'h17, 8'h08, 8'h08};
    xod_class_t  cls [16] = '{CLS_MOV_MEM_ACC, CLS_MOV_ACC_MEM, CLS_MOV_RM, CLS_MOV_RM,
      CLS_MOV_TO_SEG, CLS_PUSH_RM, CLS_PUSH_REG, CLS_PUSH_SEG, CLS_EXCHANGE_OP_RM, CLS_EXCHANGE_OP_RM,
      CLS_EXCHANGE_OP_ACC, CLS_NONE, CLS_MOV_IMM_RM, CLS_POP_RM, CLS_POP_REG, CLS_POP_SEG};
    logic [15:0] odd = 16'h0203;
    for (int i = 0; i < 16; i++) begin
      run(int'(len[i]), code[i], odd[i]);
      chk(16'(DEC_CLASS), 16'(cls[i]));
      chk({4'h0, DEC_ILLEGAL, DEC_LEN, DEC_CLOCKS},
        {4'h0, i == 11, len[i], clk[i]});
    end
  endtask : sc_table

  initial begin
    repeat (8) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk({15'h0000, BYTE_READY}, 16'h0001);
    SYS_RST = 1'b0;
    sc_walk();
    sc_regs();
    sc_segs();
    sc_forms();
    sc_override();
    sc_table();
    complete_run();
  end
endmodule : xod_operand_decode_tb_top
